// file: pkg/stpim_pkg.sv
package stpim_pkg;

  // Ports and streams
  localparam int unsigned NUM_PORTS = 3;
  localparam int unsigned NUM_PRIOS = 8;
  localparam int unsigned NUM_STREAMS = 24;
  localparam int unsigned PORT_W = 2;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned STREAM_W = 5;

  // Spanning-tree state codes, two bits per port
  localparam int unsigned STP_STATE_W = 2;
  localparam logic [1:0] STP_FORWARDING = 2'h0;
  localparam logic [1:0] STP_BLOCKING = 2'h1;
  localparam logic [1:0] STP_LEARNING = 2'h2;
  localparam logic [1:0] STP_LISTENING = 2'h3;
  localparam logic [5:0] STP_STATE_RESET = 6'h00;

  // Rate mode field
  localparam int unsigned RATE_MODE_W = 2;
  localparam logic [1:0] RATE_MODE_PORT = 2'h0;
  localparam logic [1:0] RATE_MODE_PRIO = 2'h1;
  localparam logic [1:0] RATE_MODE_PORT_PRIO = 2'h2;

  // Indirect command select field
  localparam int unsigned CMD_SEL_W = 2;
  localparam logic [1:0] CMD_SEL_RATE = 2'h0;
  localparam logic [1:0] CMD_SEL_CBS = 2'h1;
  localparam logic [1:0] CMD_SEL_EBS = 2'h2;

  // Data widths
  localparam int unsigned WDATA_W = 16;
  localparam int unsigned RATE_W = 14;
  localparam int unsigned BUCKET_W = 16;
  localparam int unsigned LEN_W = 12;
  localparam int unsigned LFSR_W = 16;

  // Reset values
  localparam logic [15:0] BUCKET_RESET = 16'h0600;
  localparam logic [15:0] BURST_SIZE_RESET = 16'h0600;
  localparam logic [13:0] RATE_RESET = 14'h0000;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  // Committed-rate time base: one step per byte-time unit
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned RATE_STEP_NS = 20;
  localparam int unsigned RATE_STEP_CYCLES =
    (RATE_STEP_NS / CLK_PERIOD_NS) < 1 ? 1 : (RATE_STEP_NS / CLK_PERIOD_NS);
  localparam int unsigned RATE_MIN_NS = 80;
  localparam int unsigned RATE_MIN_STEPS = RATE_MIN_NS / RATE_STEP_NS;
  localparam logic [13:0] RATE_MIN_RELOAD = 14'(RATE_MIN_STEPS - 1);
  localparam int unsigned STEP_CNT_W = 8;

  // Meter colours
  typedef enum logic [1:0] {
    STPIM_GREEN,
    STPIM_YELLOW,
    STPIM_RED
  } stpim_color_t;

endpackage : stpim_pkg

// file: rtl/stpim_step_tick.sv
`timescale 1ns/1ps
module stpim_step_tick
  import stpim_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Time base
  output logic step_tick
);

  typedef struct packed {
    logic [STEP_CNT_W-1:0] count;
    logic tick;
  } stpim_tick_state_t;

  stpim_tick_state_t state;
  stpim_tick_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == STEP_CNT_W'(RATE_STEP_CYCLES - 1)) begin
      next_state.count = '0;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + STEP_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign step_tick = state.tick;

endmodule : stpim_step_tick

// file: rtl/stpim_port_state.sv
`timescale 1ns/1ps
module stpim_port_state
  import stpim_pkg::*;
(
  // Two-bit state code of one port
  input wire logic [STP_STATE_W-1:0] state_code,
  // Per-port actions
  output logic rx_discard,
  output logic tx_block,
  output logic learn_enable
);

  // Disabled shares the blocking code; no other encoding exists
  always_comb begin
    unique case (state_code)
      // R1 R2 - blocking or disabled
      STP_BLOCKING: begin
        rx_discard = 1'b1;
        tx_block = 1'b1;
        learn_enable = 1'b0;
      end
      // R3 - listening
      STP_LISTENING: begin
        rx_discard = 1'b1;
        tx_block = 1'b1;
        learn_enable = 1'b0;
      end
      // R4 - learning
      STP_LEARNING: begin
        rx_discard = 1'b1;
        tx_block = 1'b1;
        learn_enable = 1'b1;
      end
      // R5 - forwarding
      STP_FORWARDING: begin
        rx_discard = 1'b0;
        tx_block = 1'b0;
        learn_enable = 1'b1;
      end
    endcase
  end

endmodule : stpim_port_state

// file: rtl/stpim_top.sv
// Summary of operation
// R1 - State 01 blocking: discard received, block transmit, no learning.
// R2 - Disabled is handled exactly as blocking, no own encoding.
// R3 - State 11 listening: discard received, block transmit, no learning.
// R4 - State 10 learning: discard received, block transmit, learning on.
// R5 - State 00 forwarding: forward, transmit and learn normally.
// R6 - Software sets static and override bits on entries host must receive.
// R7 - Software sends nothing to blocking ports; other states allowed.
// R8 - Software drops packets from ports it regards as disabled.
// R9 - Software keeps host port 0 forwarding; only network ports change.
// R10 - Green within committed burst, yellow within excess burst, else red.
// R11 - Metering and colouring happen only while the meter enable is set.
// R12 - Streams per port (3), per priority (8) or both (24) by mode.
// R13 - Each stream has own committed rate; burst sizes are shared.
// R14 - Software loads rate and burst sizes through command and write data.
// R15 - Each stream runs single-rate three-colour marking with two buckets.
// R16 - Credit committed bucket to its size; excess only when committed full.
// R17 - Rate setting is time per byte in 20 ns steps, 0-3 give 80 ns.
// R18 - Enough committed tokens: debit committed bucket, colour green.
// R19 - Else enough excess tokens: debit excess, yellow, random discard eligible.
// R20 - All buckets start at 1536 tokens after reset.
// R21 - Lower burst sizes cap a bucket only once traffic drains it below.
// R22 - Drop-on-yellow discards a random subset of yellow packets.
// R23 - Drop-on-red discards every red packet.
// R24 - Neither bucket sufficient: colour red, debit nothing.
// R25 - Each of ports 0-2 has its own two-bit state field.
`timescale 1ns/1ps
module stpim_top
  import stpim_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Spanning-tree port state, two bits per port
  input wire logic [NUM_PORTS*STP_STATE_W-1:0] spanning_tree_port_state_reg,
  // Meter configuration
  input wire logic meter_enable,
  input wire logic [RATE_MODE_W-1:0] rate_mode,
  input wire logic drop_on_yellow,
  input wire logic drop_on_red,
  // Indirect parameter load
  input wire logic ingress_meter_command_reg,
  input wire logic [CMD_SEL_W-1:0] command_select,
  input wire logic [STREAM_W-1:0] command_stream,
  input wire logic [WDATA_W-1:0] ingress_meter_write_data_reg,
  // Received packet, one-cycle strobe at end of reception
  input wire logic pkt_valid,
  input wire logic [PORT_W-1:0] pkt_port,
  input wire logic [PRIO_W-1:0] pkt_prio,
  input wire logic [LEN_W-1:0] pkt_len,
  // Per-port actions
  output logic [NUM_PORTS-1:0] port_rx_discard,
  output logic [NUM_PORTS-1:0] port_tx_block,
  output logic [NUM_PORTS-1:0] port_learn_enable,
  // Packet verdict
  output logic result_valid,
  output logic [1:0] result_color,
  output logic result_discard,
  output logic [STREAM_W-1:0] result_stream
);

  typedef struct packed {
    logic [NUM_STREAMS-1:0][BUCKET_W-1:0] committed_bucket;
    logic [NUM_STREAMS-1:0][BUCKET_W-1:0] excess_bucket;
    logic [NUM_STREAMS-1:0][RATE_W-1:0] committed_rate;
    logic [NUM_STREAMS-1:0][RATE_W-1:0] interval;
    logic [BUCKET_W-1:0] committed_burst_size;
    logic [BUCKET_W-1:0] excess_burst_size;
    logic [LFSR_W-1:0] lfsr;
    logic valid;
    logic [1:0] color;
    logic discard;
    logic [STREAM_W-1:0] stream;
  } stpim_state_t;

  stpim_state_t state;
  stpim_state_t next_state;

  logic step_tick;
  logic [NUM_PORTS-1:0] rx_discard_dec;
  logic [NUM_PORTS-1:0] tx_block_dec;
  logic [NUM_PORTS-1:0] learn_dec;
  logic [STREAM_W-1:0] pkt_stream;
  logic [BUCKET_W-1:0] len_ext;
  logic pkt_port_discard;
  stpim_color_t pkt_color;

  stpim_step_tick u_step_tick (
    .core_clk (core_clk),
    .resetn (resetn),
    .step_tick (step_tick)
  );

  // R25 per-port state
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      stpim_port_state u_port_state (
        .state_code (spanning_tree_port_state_reg[gp*STP_STATE_W +: STP_STATE_W]),
        .rx_discard (rx_discard_dec[gp]),
        .tx_block (tx_block_dec[gp]),
        .learn_enable (learn_dec[gp])
      );
    end
  endgenerate

  assign port_rx_discard = rx_discard_dec;
  assign port_tx_block = tx_block_dec;
  assign port_learn_enable = learn_dec;

  assign len_ext = BUCKET_W'(pkt_len);

  // R12 stream classification
  always_comb begin
    unique case (rate_mode)
      RATE_MODE_PORT: begin
        pkt_stream = STREAM_W'(pkt_port);
      end
      RATE_MODE_PRIO: begin
        pkt_stream = STREAM_W'(pkt_prio);
      end
      default: begin
        pkt_stream = STREAM_W'({pkt_port, pkt_prio});
      end
    endcase
  end

  // Unknown port codes are treated as discarded
  always_comb begin
    if (pkt_port < PORT_W'(NUM_PORTS)) begin
      pkt_port_discard = rx_discard_dec[pkt_port];
    end else begin
      pkt_port_discard = 1'b1;
    end
  end

  // R10 colour decision on current bucket levels
  always_comb begin
    if (state.committed_bucket[pkt_stream] >= len_ext) begin
      // R18 committed sufficient
      pkt_color = STPIM_GREEN;
    end else if (state.excess_bucket[pkt_stream] >= len_ext) begin
      // R19 excess sufficient
      pkt_color = STPIM_YELLOW;
    end else begin
      // R24 neither sufficient
      pkt_color = STPIM_RED;
    end
  end

  always_comb begin
    logic metering;
    logic drop;
    metering = 1'b0;
    drop = 1'b0;
    next_state = state;
    next_state.valid = 1'b0;

    // R14 indirect load of rate and burst sizes
    if (ingress_meter_command_reg) begin
      unique case (command_select)
        CMD_SEL_RATE: begin
          // R13 per-stream rate
          if (command_stream < STREAM_W'(NUM_STREAMS)) begin
            next_state.committed_rate[command_stream] =
              ingress_meter_write_data_reg[RATE_W-1:0];
          end
        end
        CMD_SEL_CBS: begin
          next_state.committed_burst_size = ingress_meter_write_data_reg;
        end
        CMD_SEL_EBS: begin
          next_state.excess_burst_size = ingress_meter_write_data_reg;
        end
        default: begin
        end
      endcase
    end

    // R15 per-stream token crediting
    for (int s = 0; s < NUM_STREAMS; s++) begin
      if (step_tick) begin
        if (state.interval[s] == '0) begin
          // R17 step count, floor of 80 ns
          if (state.committed_rate[s] < RATE_MIN_RELOAD) begin
            next_state.interval[s] = RATE_MIN_RELOAD;
          end else begin
            next_state.interval[s] = state.committed_rate[s];
          end
          // R16 R21 credit only while below the cap, never truncate
          if (state.committed_bucket[s] < state.committed_burst_size) begin
            next_state.committed_bucket[s] = state.committed_bucket[s] + BUCKET_W'(1);
          end else if (state.excess_bucket[s] < state.excess_burst_size) begin
            next_state.excess_bucket[s] = state.excess_bucket[s] + BUCKET_W'(1);
          end
        end else begin
          next_state.interval[s] = state.interval[s] - RATE_W'(1);
        end
      end
    end

    // R11 metering gated by enable
    metering = pkt_valid && meter_enable;
    if (metering) begin
      unique case (pkt_color)
        STPIM_GREEN: begin
          // R18 debit committed
          next_state.committed_bucket[pkt_stream] =
            next_state.committed_bucket[pkt_stream] - len_ext;
        end
        STPIM_YELLOW: begin
          // R19 debit excess
          next_state.excess_bucket[pkt_stream] =
            next_state.excess_bucket[pkt_stream] - len_ext;
          // R22 random yellow drop
          drop = drop_on_yellow && state.lfsr[0];
        end
        STPIM_RED: begin
          // R23 red drop
          drop = drop_on_red;
        end
      endcase
    end

    // Random source advances once per packet
    if (pkt_valid) begin
      if (state.lfsr[0]) begin
        next_state.lfsr = (state.lfsr >> 1) ^ LFSR_TAPS;
      end else begin
        next_state.lfsr = state.lfsr >> 1;
      end
    end

    if (pkt_valid) begin
      next_state.valid = 1'b1;
      next_state.stream = pkt_stream;
      next_state.color = metering ? pkt_color : STPIM_GREEN;
      // R1 R3 R4 received-packet discard by port state
      next_state.discard = drop || pkt_port_discard;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // R20 buckets start at 1536
      state.committed_bucket <= {NUM_STREAMS{BUCKET_RESET}};
      state.excess_bucket <= {NUM_STREAMS{BUCKET_RESET}};
      state.committed_rate <= {NUM_STREAMS{RATE_RESET}};
      state.interval <= {NUM_STREAMS{RATE_MIN_RELOAD}};
      state.committed_burst_size <= BURST_SIZE_RESET;
      state.excess_burst_size <= BURST_SIZE_RESET;
      state.lfsr <= LFSR_SEED;
      state.valid <= 1'b0;
      state.color <= 2'h0;
      state.discard <= 1'b0;
      state.stream <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign result_valid = state.valid;
  assign result_color = state.color;
  assign result_discard = state.discard;
  assign result_stream = state.stream;

endmodule : stpim_top

// file: verif/stpim_top_checker.sv
`timescale 1ns/1ps
module stpim_top_checker
  import stpim_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Inputs
  input wire logic [5:0] spanning_tree_port_state_reg,
  input wire logic meter_enable,
  input wire logic [1:0] rate_mode,
  input wire logic drop_on_red,
  input wire logic pkt_valid,
  input wire logic [1:0] pkt_port,
  input wire logic [2:0] pkt_prio,
  // Outputs
  input wire logic [2:0] port_rx_discard,
  input wire logic [2:0] port_tx_block,
  input wire logic [2:0] port_learn_enable,
  input wire logic result_valid,
  input wire logic [1:0] result_color,
  input wire logic result_discard,
  input wire logic [4:0] result_stream
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_red_seen;
    pkt_valid && drop_on_red ##1 result_valid && result_color == STPIM_RED;
  endsequence
  AST_BLOCK: assert property (spanning_tree_port_state_reg[3:2] == 2'h1 |->
    port_rx_discard[1] && port_tx_block[1] && !port_learn_enable[1]) else $error("blocking");
  AST_LISTEN: assert property (spanning_tree_port_state_reg[3:2] == 2'h3 |->
    port_rx_discard[1] && port_tx_block[1] && !port_learn_enable[1]) else $error("listening");
  AST_LEARN: assert property (spanning_tree_port_state_reg[5:4] == 2'h2 |->
    port_rx_discard[2] && port_tx_block[2] && port_learn_enable[2]) else $error("learning");
  AST_FWD: assert property (spanning_tree_port_state_reg[1:0] == 2'h0 |->
    !port_rx_discard[0] && !port_tx_block[0] && port_learn_enable[0]) else $error("forwarding");
  AST_PULSE: assert property (result_valid == $past(pkt_valid))
    else $error("verdict timing");
  AST_OFF_GREEN: assert property (pkt_valid && !meter_enable |=> result_color == STPIM_GREEN)
    else $error("colour while meter off");
  AST_STREAM_PORT: assert property (pkt_valid && rate_mode == RATE_MODE_PORT |=>
    result_stream == 5'($past(pkt_port))) else $error("port stream");
  AST_STREAM_BOTH: assert property (pkt_valid && rate_mode == RATE_MODE_PORT_PRIO |=>
    result_stream == {$past(pkt_port), $past(pkt_prio)}) else $error("port prio stream");
  AST_RED_DROP: assert property (s_red_seen |-> result_discard)
    else $error("red kept");
  AST_PORT_DISC: assert property (pkt_valid && pkt_port == 2'h2 && port_rx_discard[2] |=>
    result_discard) else $error("port discard");
endmodule : stpim_top_checker

bind stpim_top stpim_top_checker chk (.*);

// file: verif/stpim_host_model.sv
`timescale 1ns/1ps
module stpim_host_model
  import stpim_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Parameter load
  output logic ingress_meter_command_reg,
  output logic [1:0] command_select,
  output logic [4:0] command_stream,
  output logic [15:0] ingress_meter_write_data_reg,
  // Packet strobe
  output logic pkt_valid,
  output logic [1:0] pkt_port,
  output logic [2:0] pkt_prio,
  output logic [11:0] pkt_len
);
  initial begin
    ingress_meter_command_reg = 1'b0;
    command_select = 2'h3;
    command_stream = 5'h1F;
    ingress_meter_write_data_reg = 16'h0000;
    pkt_valid = 1'b0;
    pkt_port = 2'h0;
    pkt_prio = 3'h0;
    pkt_len = 12'h000;
  end
  // address-table entries belong to software outside this model
  task automatic load(input logic [1:0] sel, input logic [4:0] s, input logic [15:0] d);
    @(posedge core_clk);
    ingress_meter_command_reg <= 1'b1;
    command_select <= sel;
    command_stream <= s;
    ingress_meter_write_data_reg <= d;
    @(posedge core_clk);
    ingress_meter_command_reg <= 1'b0;
    ingress_meter_write_data_reg <= ~d;
  endtask : load
  // one-cycle strobe; stale priority and length scrambled afterwards, port kept
  task automatic send(input logic [1:0] p, input logic [2:0] q, input logic [11:0] n);
    @(posedge core_clk);
    pkt_valid <= 1'b1;
    pkt_port <= p;
    pkt_prio <= q;
    pkt_len <= n;
    @(posedge core_clk);
    pkt_valid <= 1'b0;
    pkt_prio <= ~q;
    pkt_len <= ~n;
  endtask : send
endmodule : stpim_host_model

// file: verif/stpim_top_tb.sv
`timescale 1ns/1ps
module stpim_top_tb
  import stpim_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] spanning_tree_port_state_reg = 6'h00;
  logic meter_enable = 1'b0;
  logic [1:0] rate_mode = 2'h0;
  logic drop_on_yellow = 1'b0;
  logic drop_on_red = 1'b0;
  logic ingress_meter_command_reg;
  logic [1:0] command_select;
  logic [4:0] command_stream;
  logic [15:0] ingress_meter_write_data_reg;
  logic pkt_valid;
  logic [1:0] pkt_port;
  logic [2:0] pkt_prio;
  logic [11:0] pkt_len;
  logic [2:0] port_rx_discard;
  logic [2:0] port_tx_block;
  logic [2:0] port_learn_enable;
  logic result_valid;
  logic [1:0] result_color;
  logic result_discard;
  logic [4:0] result_stream;
  int errors = 0;
  int n_tests = 0;
  int n_drop = 0;
  logic [1:0] code;

  always #10 core_clk = ~core_clk;

  stpim_top uut (.*);
  stpim_host_model host (.*);

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  // Stream 5'h1F skips the stream compare
  task automatic pkt(input logic [1:0] p, input logic [2:0] q, input logic [11:0] n,
      input logic [1:0] col, input logic disc, input logic [4:0] s);
    host.send(p, q, n);
    #1;
    chk("result_valid", 16'(result_valid), 16'h0001);
    chk("result_color", 16'(result_color), 16'(col));
    chk("result_discard", 16'(result_discard), 16'(disc));
    if (s != 5'h1F) chk("result_stream", 16'(result_stream), 16'(s));
  endtask : pkt

  task automatic cfg(input logic [5:0] st, input logic en, input logic [1:0] m);
    @(posedge core_clk);
    spanning_tree_port_state_reg <= st;
    meter_enable <= en;
    rate_mode <= m;
    drop_on_red <= 1'b1;
  endtask : cfg

  task automatic test_done;
    $display("comparisons %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      cfg({2'(c + 2), 2'(c + 1), 2'(c)}, 1'b0, 2'h0);
      @(posedge core_clk);
      #1;
      for (int p = 0; p < 3; p++) begin
        code = 2'(c + p);
        chk("rx_discard", 16'(port_rx_discard[p]), 16'(code != 2'h0));
        chk("tx_block", 16'(port_tx_block[p]), 16'(code != 2'h0));
        chk("learn", 16'(port_learn_enable[p]), 16'(code[0] == 1'b0));
      end
    end
    cfg(6'h00, 1'b1, RATE_MODE_PORT);
    pkt(2'h1, 3'h0, 12'h600, STPIM_GREEN, 1'b0, 5'h01);
    pkt(2'h1, 3'h0, 12'h600, STPIM_YELLOW, 1'b0, 5'h01);
    pkt(2'h1, 3'h0, 12'h600, STPIM_RED, 1'b1, 5'h01);
    pkt(2'h2, 3'h0, 12'h600, STPIM_GREEN, 1'b0, 5'h02);
    cfg(6'h00, 1'b1, RATE_MODE_PRIO);
    pkt(2'h0, 3'h5, 12'h400, STPIM_GREEN, 1'b0, 5'h05);
    cfg(6'h00, 1'b1, RATE_MODE_PORT_PRIO);
    pkt(2'h1, 3'h3, 12'h400, STPIM_GREEN, 1'b0, 5'h0B);
    cfg(6'h00, 1'b1, 2'h3);
    pkt(2'h2, 3'h7, 12'h400, STPIM_GREEN, 1'b0, 5'h17);
    cfg(6'h00, 1'b0, RATE_MODE_PORT);
    pkt(2'h1, 3'h0, 12'h600, STPIM_GREEN, 1'b0, 5'h1F);
    cfg(6'h04, 1'b0, RATE_MODE_PORT);
    pkt(2'h1, 3'h0, 12'h010, STPIM_GREEN, 1'b1, 5'h1F);
    cfg(6'h00, 1'b1, RATE_MODE_PORT);
    host.load(CMD_SEL_RATE, 5'h00, 16'h0009);
    pkt(2'h0, 3'h0, 12'h600, STPIM_GREEN, 1'b0, 5'h00);
    repeat (400) @(posedge core_clk);
    pkt(2'h0, 3'h0, 12'h01E, STPIM_GREEN, 1'b0, 5'h00);
    pkt(2'h0, 3'h0, 12'h00F, STPIM_YELLOW, 1'b0, 5'h00);
    host.load(CMD_SEL_CBS, 5'h00, 16'h0064);
    cfg(6'h00, 1'b1, RATE_MODE_PRIO);
    pkt(2'h0, 3'h6, 12'h3E8, STPIM_GREEN, 1'b0, 5'h06);
    // Empty the committed bucket of stream 7, then send yellow packets
    pkt(2'h0, 3'h7, 12'h600, STPIM_GREEN, 1'b0, 5'h07);
    @(posedge core_clk);
    drop_on_yellow <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      host.send(2'h0, 3'h7, 12'h020);
      #1;
      chk("yellow_color", 16'(result_color), 16'(STPIM_YELLOW));
      if (result_discard === 1'b1) n_drop++;
    end
    // Random subset: some dropped, some kept
    chk("yellow_subset", 16'(n_drop != 0 && n_drop != 16), 16'h0001);
    test_done();
  end
endmodule : stpim_top_tb
